// ### verilog/olc_pkg.sv
package olc_pkg;

    // Overload content: percent in the integer byte, 16 fraction bits
    localparam int OL_FRAC = 16;
    localparam logic [7:0] PCT_FULL = 8'h64;
    localparam logic [23:0] OL_FULL = 24'h640000;

    // Setting limits and reset values
    localparam logic [13:0] COOL_MIN = 14'h000A;
    localparam logic [13:0] COOL_MAX = 14'h270F;
    localparam logic [13:0] COOL_RST = 14'h012C;
    localparam logic [6:0] ALARM_MIN = 7'h01;
    localparam logic [6:0] ALARM_MAX = 7'h64;
    localparam logic [6:0] ALARM_RST = 7'h5A;
    localparam logic [6:0] LOCK_MIN = 7'h01;
    localparam logic [6:0] LOCK_MAX = 7'h63;
    localparam logic [6:0] LOCK_RST = 7'h0F;

    // Sample tick and decay scaling
    localparam int CLK_HZ = 25000000;
    localparam int TICK_MS = 100;
    localparam int TICK_CYCLES_DEF = CLK_HZ / 1000 * TICK_MS;
    localparam int TENTH_MIN_MS = 6000;
    localparam int DECAY_EXP = 5;
    localparam int DEN_MULT = TENTH_MIN_MS / (DECAY_EXP * TICK_MS);

    // Start history
    localparam int HIST_DEPTH = 4;
    localparam logic [2:0] HIST_FULL = 3'h4;
    localparam int AVG_SHIFT = 2;
    localparam int SAFETY_SHIFT = 2;

    // Register offsets
    localparam logic [7:0] A_COOL = 8'h00;
    localparam logic [7:0] A_ALARM = 8'h04;
    localparam logic [7:0] A_LOCK = 8'h08;
    localparam logic [7:0] A_CTRL = 8'h0C;
    localparam logic [7:0] A_STATUS = 8'h10;
    localparam logic [7:0] A_INT_STAT = 8'h14;
    localparam logic [7:0] A_INT_MASK = 8'h18;

    // Control bits
    localparam int CTRL_AUTO = 0;
    localparam int CTRL_RELAY = 1;

    // Status fields
    localparam int ST_PCT_LSB = 0;
    localparam int ST_ALARM = 8;
    localparam int ST_LOCK = 9;
    localparam int ST_FULL = 10;
    localparam int ST_STARTING = 11;
    localparam int ST_LVL_LSB = 16;

    // Interrupt bits
    localparam int INT_W = 4;
    localparam int IRQ_ALARM = 0;
    localparam int IRQ_LOCK = 1;
    localparam int IRQ_RELEASE = 2;
    localparam int IRQ_HIST = 3;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_DIV = 3'b010,
        ST_APPLY = 3'b100
    } olc_state_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic we;
        logic re;
    } olc_bus_req_t;

    typedef struct packed {
        olc_state_t state;
        logic [21:0] tick_cnt;
        logic [23:0] content;
        logic [13:0] cool;
        logic [6:0] alarm_lvl;
        logic [6:0] lock_lvl;
        logic auto_sel;
        logic relay_en;
        logic alarm;
        logic lockout;
        logic [INT_W-1:0] int_stat;
        logic [INT_W-1:0] int_mask;
        logic [7:0] start_pct;
        logic starting;
        logic [9:0] hist_sum;
        logic [2:0] hist_cnt;
        logic [1:0] hist_ptr;
        logic [31:0] rdata;
        logic div_go;
    } olc_core_t;

    typedef struct packed {
        logic busy;
        logic done;
        logic [4:0] cnt;
        logic [18:0] rem;
        logic [23:0] quo;
    } olc_div_st_t;

    typedef struct packed {
        logic [3:0][7:0] mem;
        logic [7:0] rdata;
    } olc_mem_st_t;

endpackage

// ### verilog/olc_div.sv
`timescale 1ns/1ps
// Serial restoring divider, one quotient bit per clock
module olc_div (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Request
    input wire logic go_i,
    input wire logic [23:0] num_i,
    input wire logic [17:0] den_i,
    // Result
    output logic [23:0] quo_o,
    output logic done_o
);
    import olc_pkg::*;

    olc_div_st_t s_q, s_d;
    logic [18:0] trial;

    // One shift-subtract step per cycle while busy
    always_comb begin
        s_d = s_q;
        s_d.done = 1'b0;
        trial = {s_q.rem[17:0], s_q.quo[23]};
        if (go_i && !s_q.busy) begin
            s_d.busy = 1'b1;
            s_d.cnt = 5'h18;
            s_d.rem = 19'h00000;
            s_d.quo = num_i;
        end else if (s_q.busy) begin
            if (trial >= {1'b0, den_i}) begin
                s_d.rem = trial - {1'b0, den_i};
                s_d.quo = {s_q.quo[22:0], 1'b1};
            end else begin
                s_d.rem = trial;
                s_d.quo = {s_q.quo[22:0], 1'b0};
            end
            s_d.cnt = s_q.cnt - 5'h01;
            if (s_q.cnt == 5'h01) begin
                s_d.busy = 1'b0;
                s_d.done = 1'b1;
            end
        end
    end

    // State register
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign quo_o = s_q.quo;
    assign done_o = s_q.done;

endmodule

// ### verilog/olc_hist_mem.sv
`timescale 1ns/1ps
// Four-entry start history with registered read
module olc_hist_mem (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Write port
    input wire logic we_i,
    input wire logic [1:0] waddr_i,
    input wire logic [7:0] wdata_i,
    // Read port
    input wire logic [1:0] raddr_i,
    output logic [7:0] rdata_o
);
    import olc_pkg::*;

    olc_mem_st_t s_q, s_d;

    // Write and read of the array
    always_comb begin
        s_d = s_q;
        s_d.rdata = s_q.mem[raddr_i];
        if (we_i) begin
            s_d.mem[waddr_i] = wdata_i;
        end
    end

    // State register
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign rdata_o = s_q.rdata;

endmodule

// ### verilog/olc_core.sv
`timescale 1ns/1ps
// Functional notes
// RULE1: Content held as percent, 0 to 100
// RULE2: Cooling time spans full to under 1%
// RULE3: Stopped motor decays exponentially, exponent 5t/T
// RULE4: Cooling time 1.0-999.9 min, reset 30.0
// RULE5: Alarm at programmed level, 1-100, default 90
// RULE6: Relay output follows alarm when configured
// RULE7: Trip locks out until below level 15
// RULE8: Auto level select, off or auto, off
// RULE9: Average last four good starts, integer math
// RULE10: Scale averaged consumption by 1.25
// RULE11: Auto release level is 100 minus scaled
// RULE12: Latch content when start command given
// RULE13: Record consumption only on reaching speed
// RULE14: Auto mode locks out below full content
// RULE15: Update and compare once per sample tick
module olc_core #(
    parameter int unsigned TICK_CYCLES = olc_pkg::TICK_CYCLES_DEF
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Register port
    input olc_pkg::olc_bus_req_t bus_i,
    output logic [31:0] rdata_o,
    // Overload accumulator
    input wire logic [7:0] ol_acc_i,
    input wire logic trip_i,
    input wire logic run_i,
    // Start control
    input wire logic start_cmd_i,
    input wire logic up_to_speed_i,
    output logic start_permit_o,
    // Flags and relay
    output logic alarm_o,
    output logic alarm_relay_o,
    output logic lockout_o,
    output logic irq_o
);
    import olc_pkg::*;

    olc_core_t c_q, c_d;
    logic tick;
    logic [7:0] pct;
    logic [7:0] acc_pct;
    logic hist_full;
    logic [7:0] avg;
    logic [9:0] scaled;
    logic [7:0] auto_lvl;
    logic [7:0] release_lvl;
    logic [17:0] den;
    logic [23:0] quo;
    logic div_done;
    logic [23:0] step;
    logic [7:0] oldest;
    logic [7:0] used;
    logic rec;
    logic start_ok;
    logic [INT_W-1:0] ev;
    logic [INT_W-1:0] w1c;

    // Integer percent of a fixed-point content value
    function automatic logic [7:0] pct_of(input logic [23:0] v);
        pct_of = v[23:OL_FRAC];
    endfunction

    // Limit a written setting to its legal span
    function automatic logic [13:0] clamp(input logic [13:0] v,
                                          input logic [13:0] lo,
                                          input logic [13:0] hi);
        if (v < lo) begin
            clamp = lo;
        end else if (v > hi) begin
            clamp = hi;
        end else begin
            clamp = v;
        end
    endfunction

    // Decay step: content divided by 12 times cooling tenths
    olc_div u_div (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .go_i(c_q.div_go),
        .num_i(c_q.content),
        .den_i(den),
        .quo_o(quo),
        .done_o(div_done)
    );

    // History of start consumption, oldest entry at the write pointer
    olc_hist_mem u_hist (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .we_i(rec),
        .waddr_i(c_q.hist_ptr),
        .wdata_i(used),
        .raddr_i(c_q.hist_ptr),
        .rdata_o(oldest)
    );

    // Derived values
    assign tick = (c_q.tick_cnt == 22'(TICK_CYCLES - 1)); // RULE15
    assign pct = pct_of(c_q.content);
    assign acc_pct = (ol_acc_i > PCT_FULL) ? PCT_FULL : ol_acc_i; // RULE1
    assign den = 18'(c_q.cool) * 18'(DEN_MULT); // RULE2
    assign step = (quo == 24'h000000) ? 24'h000001 : quo;
    assign hist_full = (c_q.hist_cnt == HIST_FULL);
    assign avg = 8'(c_q.hist_sum >> AVG_SHIFT); // RULE9
    assign scaled = {2'b00, avg} + {2'b00, avg >> SAFETY_SHIFT}; // RULE10
    assign auto_lvl = (scaled >= 10'(PCT_FULL - 8'h01)) ? 8'h01 :
                      PCT_FULL - scaled[7:0]; // RULE11
    assign release_lvl = (c_q.auto_sel && hist_full) ? auto_lvl :
                         {1'b0, c_q.lock_lvl}; // RULE8
    assign start_ok = start_cmd_i && !c_q.lockout && !c_q.starting &&
                      !trip_i; // RULE7
    assign rec = c_q.starting && up_to_speed_i && !trip_i; // RULE13
    assign used = (pct > c_q.start_pct) ? pct - c_q.start_pct : 8'h00;
    assign w1c = (bus_i.we && bus_i.addr == A_INT_STAT) ?
                 bus_i.wdata[INT_W-1:0] : '0;

    // Next state of the whole block
    always_comb begin
        c_d = c_q;
        c_d.div_go = 1'b0;
        ev = '0;
        c_d.tick_cnt = tick ? 22'h000000 : c_q.tick_cnt + 22'h000001;

        // Content update and comparisons on the sample tick
        if (tick) begin
            if (run_i) begin
                c_d.content = {acc_pct, 16'h0000};
            end else if (c_q.content != 24'h000000 &&
                         c_q.state == ST_IDLE) begin
                c_d.div_go = 1'b1; // RULE3
                c_d.state = ST_DIV;
            end
            c_d.alarm = (pct >= {1'b0, c_q.alarm_lvl}); // RULE5
            ev[IRQ_ALARM] = c_d.alarm && !c_q.alarm;
            if (c_q.lockout && pct < release_lvl) begin
                c_d.lockout = 1'b0; // RULE7
                ev[IRQ_RELEASE] = 1'b1;
            end else if (c_q.auto_sel && hist_full && !run_i &&
                         !c_q.starting && pct >= auto_lvl) begin
                c_d.lockout = 1'b1; // RULE14
                ev[IRQ_LOCK] = !c_q.lockout;
            end
        end

        // Decay sequencing
        unique case (c_q.state)
            ST_IDLE: begin
            end
            ST_DIV: begin
                if (div_done) begin
                    c_d.state = ST_APPLY;
                end
            end
            ST_APPLY: begin
                if (!run_i) begin
                    c_d.content = (c_q.content > step) ?
                                  c_q.content - step : 24'h000000; // RULE3
                end
                c_d.state = ST_IDLE;
            end
        endcase

        // A trip locks out at once and aborts a start
        if (trip_i) begin
            c_d.lockout = 1'b1; // RULE7
            c_d.starting = 1'b0;
            ev[IRQ_LOCK] = !c_q.lockout;
        end

        // Start latch and history update
        if (start_ok) begin
            c_d.start_pct = pct; // RULE12
            c_d.starting = 1'b1;
        end else if (rec) begin
            c_d.starting = 1'b0;
            c_d.hist_ptr = c_q.hist_ptr + 2'h1;
            c_d.hist_sum = c_q.hist_sum + {2'b00, used} -
                           (hist_full ? {2'b00, oldest} : 10'h000); // RULE9
            if (!hist_full) begin
                c_d.hist_cnt = c_q.hist_cnt + 3'h1;
            end
            ev[IRQ_HIST] = 1'b1;
        end

        // Register writes
        if (bus_i.we) begin
            unique case (bus_i.addr)
                A_COOL: c_d.cool = clamp(bus_i.wdata[13:0],
                                         COOL_MIN, COOL_MAX); // RULE4
                A_ALARM: c_d.alarm_lvl = 7'(clamp({7'h00,
                    bus_i.wdata[6:0]}, 14'(ALARM_MIN), 14'(ALARM_MAX)));
                A_LOCK: c_d.lock_lvl = 7'(clamp({7'h00,
                    bus_i.wdata[6:0]}, 14'(LOCK_MIN), 14'(LOCK_MAX)));
                A_CTRL: begin
                    c_d.auto_sel = bus_i.wdata[CTRL_AUTO]; // RULE8
                    c_d.relay_en = bus_i.wdata[CTRL_RELAY];
                end
                A_INT_MASK: c_d.int_mask = bus_i.wdata[INT_W-1:0];
                default: begin
                end
            endcase
        end

        // Sticky events: a new event wins over a clear
        c_d.int_stat = (c_q.int_stat & ~w1c) | ev;

        // Register reads, data in the following cycle
        c_d.rdata = 32'h00000000;
        if (bus_i.re) begin
            unique case (bus_i.addr)
                A_COOL: c_d.rdata = {18'h00000, c_q.cool};
                A_ALARM: c_d.rdata = {25'h0000000, c_q.alarm_lvl};
                A_LOCK: c_d.rdata = {25'h0000000, c_q.lock_lvl};
                A_CTRL: c_d.rdata = {30'h00000000, c_q.relay_en,
                                     c_q.auto_sel};
                A_STATUS: begin
                    c_d.rdata[ST_PCT_LSB +: 8] = pct;
                    c_d.rdata[ST_ALARM] = c_q.alarm;
                    c_d.rdata[ST_LOCK] = c_q.lockout;
                    c_d.rdata[ST_FULL] = hist_full;
                    c_d.rdata[ST_STARTING] = c_q.starting;
                    c_d.rdata[ST_LVL_LSB +: 8] = release_lvl;
                end
                A_INT_STAT: c_d.rdata = {28'h0000000, c_q.int_stat};
                A_INT_MASK: c_d.rdata = {28'h0000000, c_q.int_mask};
                default: c_d.rdata = 32'h00000000;
            endcase
        end
    end

    // State register
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            c_q <= '0;
            c_q.state <= ST_IDLE;
            c_q.cool <= COOL_RST; // RULE4
            c_q.alarm_lvl <= ALARM_RST; // RULE5
            c_q.lock_lvl <= LOCK_RST; // RULE7
            c_q.relay_en <= 1'b1;
        end else begin
            c_q <= c_d;
        end
    end

    // Outputs
    assign rdata_o = c_q.rdata;
    assign alarm_o = c_q.alarm;
    assign alarm_relay_o = c_q.alarm && c_q.relay_en; // RULE6
    assign lockout_o = c_q.lockout;
    assign start_permit_o = !c_q.lockout; // RULE7
    assign irq_o = |(c_q.int_stat & c_q.int_mask);

    // Checks
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_n_i);

    AST_CONTENT_MAX: assert property ( // RULE1
        c_q.content <= OL_FULL)
        else $error("content above full scale");
    AST_COOL_RANGE: assert property ( // RULE4
        c_q.cool >= COOL_MIN && c_q.cool <= COOL_MAX)
        else $error("cooling time out of range");
    AST_ALARM_TICK: assert property ( // RULE5
        tick |=> c_q.alarm == ($past(pct) >= {1'b0, $past(c_q.alarm_lvl)}))
        else $error("alarm does not match level");
    AST_ALARM_HOLD: assert property ( // RULE15
        !tick |=> $stable(c_q.alarm))
        else $error("alarm changed off tick");
    AST_RELAY: assert property ( // RULE6
        c_q.relay_en && $rose(c_q.alarm) |-> alarm_relay_o)
        else $error("relay not following alarm");
    AST_TRIP_LOCK: assert property ( // RULE7
        trip_i |=> lockout_o && !start_permit_o)
        else $error("trip did not lock out");
    AST_LOCK_BLOCKS: assert property ( // RULE7
        c_q.lockout && !c_q.starting && start_cmd_i |=> !c_q.starting)
        else $error("start accepted under lockout");
    AST_DECAY: assert property ( // RULE3
        c_q.state == ST_APPLY && !run_i && c_q.content != 24'h000000
        |=> c_q.content < $past(c_q.content))
        else $error("content did not decay");
    AST_DECAY_TIME: assert property ( // RULE3
        c_q.div_go |-> ##[1:30] c_q.state == ST_APPLY)
        else $error("decay step overdue");
    AST_CAPTURE: assert property ( // RULE12
        start_ok |=> c_q.start_pct == $past(pct) && c_q.starting)
        else $error("start content not latched");
    AST_HIST_CAUSE: assert property ( // RULE13
        c_q.hist_ptr != $past(c_q.hist_ptr) |->
        $past(c_q.starting && up_to_speed_i))
        else $error("history grew without a good start");

    COV_TRIP_RELEASE: cover property (
        $fell(c_q.lockout));
    COV_AUTO_LOCK: cover property (
        c_q.auto_sel && hist_full && $rose(c_q.lockout) && !trip_i);
    COV_ALARM: cover property (
        $rose(alarm_relay_o));
    COV_HIST_WRAP: cover property (
        rec && hist_full);

endmodule

// ### test/olc_far.sv
`timescale 1ns/1ps
// Far side: accumulator, start control and speed detector
module olc_far (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Requests from the bench
    input wire logic [7:0] pct_i,
    input wire logic run_i,
    input wire logic start_i,
    input wire logic trip_i,
    input wire logic late_uts_i,
    input wire logic [7:0] dly_i,
    // Lines toward the block
    output logic [7:0] ol_acc_o,
    output logic trip_o,
    output logic run_o,
    output logic start_cmd_o,
    output logic up_to_speed_o
);
    logic [7:0] cnt_q;
    logic live_q;

    // Accumulator content and run state pass straight through
    assign ol_acc_o = pct_i;
    assign run_o = run_i;

    // Start pulse, then speed report after dly_i cycles; a trip aborts unless late_uts_i is set
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            cnt_q <= 8'h00;
            live_q <= 1'b0;
            start_cmd_o <= 1'b0;
            trip_o <= 1'b0;
            up_to_speed_o <= 1'b0;
        end else begin
            start_cmd_o <= start_i;
            trip_o <= trip_i;
            up_to_speed_o <= live_q && cnt_q == 8'h01;
            if (start_i) begin
                cnt_q <= dly_i;
                live_q <= 1'b1;
            end else if (trip_i && !late_uts_i) begin
                live_q <= 1'b0;
            end else if (cnt_q != 8'h00) begin
                cnt_q <= cnt_q - 8'h01;
            end
        end
    end
endmodule

// ### test/olc_tb.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin \
    total_checks++; \
    if ((g) !== (e)) begin \
        bad_count++; \
        $display("unexpected %s exp %0h got %0h", n, e, g); \
    end \
end
module tb;
    import olc_pkg::*;
    typedef struct {logic [31:0] e; logic [31:0] m;} olc_exp_t;
    localparam int TK = 50;
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    olc_bus_req_t bus = '0;
    logic [7:0] pct = 8'h00;
    logic run = 1'b0;
    logic st = 1'b0;
    logic tr = 1'b0;
    logic late = 1'b0;
    logic [7:0] dly = 8'h78;
    logic [7:0] ol, p;
    logic trp, rn, scmd, uts, re_q;
    logic [31:0] rdata, rs = 32'h5B;
    logic permit, alarm, relay, lockout, irq;
    int bad_count = 0;
    int total_checks = 0;
    int cyc = 0;
    int t0, k;
    olc_exp_t q[$];
    logic [7:0] ca [6] = '{A_COOL, A_COOL, A_ALARM, A_ALARM, A_LOCK, A_LOCK};
    logic [31:0] cw [6] = '{32'h0, 32'h3FFF, 32'h0, 32'h7F, 32'h0, 32'h64};
    logic [31:0] ce [6] = '{32'hA, 32'h270F, 32'h1, 32'h64, 32'h1, 32'h63};
    logic [7:0] sa [4] = '{8'h0A, 8'h14, 8'h05, 8'h1E};
    logic [7:0] sb [4] = '{8'h28, 8'h31, 8'h23, 8'h39};

    always #20 clk_i = ~clk_i;

    olc_far u_far (.clk_i(clk_i), .rst_n_i(rst_n_i), .pct_i(pct),
        .run_i(run), .start_i(st), .trip_i(tr), .late_uts_i(late),
        .dly_i(dly), .ol_acc_o(ol), .trip_o(trp), .run_o(rn),
        .start_cmd_o(scmd), .up_to_speed_o(uts));

    olc_core #(.TICK_CYCLES(TK)) u_dut (.clk_i(clk_i), .rst_n_i(rst_n_i),
        .bus_i(bus), .rdata_o(rdata), .ol_acc_i(ol), .trip_i(trp),
        .run_i(rn), .start_cmd_i(scmd), .up_to_speed_i(uts),
        .start_permit_o(permit), .alarm_o(alarm),
        .alarm_relay_o(relay), .lockout_o(lockout), .irq_o(irq));

    // Read data checked against the oldest note, one cycle after re
    always @(posedge clk_i) begin
        olc_exp_t x;
        cyc++;
        if (re_q) begin
            x = q.pop_front();
            `CHK("rdata", x.e, rdata & x.m)
        end
        re_q = bus.re;
        if (cyc > 50000) begin
            bad_count++;
            finish_test();
        end
    end

    function automatic logic [31:0] xs();
        rs ^= rs << 13;
        rs ^= rs >> 17;
        rs ^= rs << 5;
        return rs;
    endfunction

    // Idle the bus and pulse requests, then let n edges pass
    task automatic cy(input int n);
        bus <= '0;
        st <= 1'b0;
        tr <= 1'b0;
        repeat (n) @(posedge clk_i);
    endtask

    // One spare tick: flags are judged on the content of the tick before
    task automatic tk(input int n);
        cy((n + 1) * TK + 30);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus <= '{a, d, 1'b1, 1'b0};
        @(posedge clk_i);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e,
                      input logic [31:0] m);
        q.push_back('{e, m});
        bus <= '{a, 32'h0, 1'b0, 1'b1};
        @(posedge clk_i);
    endtask

    task automatic wait_free();
        for (int n = 0; n < 20000 && lockout !== 1'b0; n++) cy(1);
    endtask

    task automatic done(input string s);
        $display("test %s ended", s);
    endtask

    task automatic finish_test();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        cy(16);
        rst_n_i <= 1'b1;
        cy(1);
        rd(A_COOL, 32'h12C, '1);
        rd(A_ALARM, 32'h5A, '1);
        rd(A_LOCK, 32'hF, '1);
        rd(A_CTRL, 32'h2, '1);
        rd(A_STATUS, 32'h000F0000, '1);
        rd(8'h1C, 32'h0, '1);
        cy(2);
        done("defaults");
        for (int i = 0; i < 6; i++) begin
            wr(ca[i], cw[i]);
            rd(ca[i], ce[i], '1);
        end
        wr(A_COOL, 32'hA);
        wr(A_ALARM, 32'h5A);
        wr(A_LOCK, 32'hF);
        cy(2);
        done("limits");
        run <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            p = (i == 0) ? 8'h59 : (i == 1) ? 8'h5A : 8'(xs() % 101);
            pct <= p;
            tk(1);
            `CHK("alarm", p >= 8'h5A, alarm)
            `CHK("relay", p >= 8'h5A, relay)
        end
        done("alarm sweep");
        pct <= 8'h00;
        tk(1);
        `CHK("alarm", 1'b0, alarm)
        wr(A_INT_MASK, 32'h1);
        wr(A_INT_STAT, 32'hF);
        pct <= 8'hC8;
        tk(1);
        `CHK("alarm", 1'b1, alarm)
        `CHK("irq", 1'b1, irq)
        rd(A_STATUS, 32'h164, 32'h1FF);
        wr(A_CTRL, 32'h0);
        cy(2);
        `CHK("relay", 1'b0, relay)
        wr(A_CTRL, 32'h2);
        wr(A_INT_STAT, 32'h1);
        cy(2);
        `CHK("irq", 1'b0, irq)
        tr <= 1'b1;
        @(posedge clk_i);
        cy(3);
        `CHK("lockout", 1'b1, lockout)
        `CHK("permit", 1'b0, permit)
        `CHK("irq", 1'b0, irq)
        rd(A_INT_STAT, 32'h2, 32'h2);
        run <= 1'b0;
        t0 = cyc;
        st <= 1'b1;
        @(posedge clk_i);
        cy(4);
        rd(A_STATUS, 32'h0, 32'h800);
        tk(20);
        `CHK("alarm", 1'b0, alarm)
        wait_free();
        k = (cyc - t0) / TK;
        rd(A_STATUS, 32'hE, 32'h2FF);
        rd(A_INT_STAT, 32'h4, 32'h4);
        cy(2);
        `CHK("release tick", 1'b1, k >= 222 && k <= 234)
        `CHK("permit", 1'b1, permit)
        while (cyc < t0 + 530 * TK) cy(1);
        rd(A_STATUS, 32'h1, 32'hFF);
        while (cyc < t0 + 610 * TK) cy(1);
        rd(A_STATUS, 32'h0, 32'hFF);
        cy(2);
        done("trip and cooling");
        wr(A_CTRL, 32'h3);
        wr(A_INT_STAT, 32'hF);
        run <= 1'b1;
        pct <= 8'h0A;
        late <= 1'b1;
        tk(1);
        st <= 1'b1;
        @(posedge clk_i);
        cy(3);
        tr <= 1'b1;
        @(posedge clk_i);
        cy(130);
        rd(A_INT_STAT, 32'h2, 32'hA);
        cy(2);
        `CHK("lockout", 1'b0, lockout)
        late <= 1'b0;
        wr(A_INT_STAT, 32'hF);
        for (int i = 0; i < 4; i++) begin
            pct <= sa[i];
            tk(1);
            st <= 1'b1;
            @(posedge clk_i);
            pct <= sb[i];
            cy(130);
            rd(A_INT_STAT, 32'h8, 32'h8);
            wr(A_INT_STAT, 32'h8);
        end
        rd(A_STATUS, 32'h400400, 32'hFF0C00);
        pct <= 8'h46;
        tk(1);
        run <= 1'b0;
        tk(1);
        `CHK("lockout", 1'b1, lockout)
        rd(A_STATUS, 32'h400200, 32'hFF0200);
        wait_free();
        rd(A_STATUS, 32'h3F, 32'h2FF);
        cy(2);
        done("auto level");
        finish_test();
    end
endmodule
